// file: verilog/memps_top.sv
// event enable, event flags, phase source and computation mode registers
//
// Overview of operation
// - enable bit 0 gates total-power no-load entry onto the interrupt line
// - enable bit 1 gates fundamental no-load entry; ignored without fundamental metering
// - enable bit 2 gates apparent-power no-load entry onto the interrupt line
// - enable bits 3-8 gate missing crossings: volt a,b,c then current a,b,c
// - enable bits 9-14 gate detected crossings: volt a,b,c then current a,b,c
// - enable bit 15 writable either way, no effect; reset-finished never masked
// - enable bit 16 gates voltage dip; causing phase shown in phase source
// - enable bit 17 gates overcurrent on any phase
// - enable bit 18 gates overvoltage on any phase
// - enable bit 19 gates phase order fault: a rise followed by c rise
// - enable bit 20 gates neutral current disagreement beyond limit
// - enable bits 23, 24 gate current and voltage peak period end
// - enable bits 21-22, 25-31 reserved, read zero; all enables reset zero
// - phase source bits 3-5 mark phase a-c causing overcurrent flag
// - phase source bits 9-11 mark phase a-c causing overvoltage flag
// - phase source bits 12-14 mark dip phase; other bits read zero
// - no-load bits 0-2 show total-power idle phases, set with flag 0
// - no-load bits 3-5 show fundamental idle phases, set with flag 1
// - no-load bits 6-8 show apparent idle phases, set with flag 2; rest zero
// - mode bits 0-2, reset one, pick phases for first pulse sum
// - mode bits 3-5 and 6-8, reset one, pick phases for second, third
// - after reset or power return, reset-finished flag set, line driven low
`timescale 1ns/1ps
module memps_top
   import memps_pkg::*;
#(
   parameter bit HAS_FUNDAMENTAL = 1'b1
) (
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic [15:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire memps_events_t EVENTS,
   input wire memps_phase_t PHASE,
   output logic [31:0] REG_RDATA,
   output logic REG_RVALID,
   output logic SECOND_INTERRUPT_LINE_N,
   output logic [2:0] PULSE_ONE_PHASE_PICK,
   output logic [2:0] PULSE_TWO_PHASE_PICK,
   output logic [2:0] PULSE_THREE_PHASE_PICK
);

   logic [31:0] event_enable_second;
   logic [31:0] event_flags_second;
   logic [15:0] phase_event_source;
   logic [15:0] phase_no_load_state;
   logic [CM_PICK_W-1:0] computation_mode;
   logic [2:0] prev_total_idle;
   logic [2:0] prev_fund_idle;
   logic [2:0] prev_app_idle;
   logic [2:0] fund_idle_in;
   logic wr_enable;
   logic wr_flags;
   logic wr_mode;
   logic [31:0] flag_set;
   logic [31:0] flag_clr;
   logic [31:0] next_flags;
   logic [31:0] next_enable;
   logic next_irq_n;

   // the register port comes from the serial interface logic on this clock
   assign wr_enable = REG_WR && (REG_ADDR == MEMPS_ADDR_ENABLE);
   assign wr_flags = REG_WR && (REG_ADDR == MEMPS_ADDR_FLAGS);
   assign wr_mode = REG_WR && (REG_ADDR == MEMPS_ADDR_COMP_MODE);

   // parts without fundamental metering never report this idle state
   assign fund_idle_in = HAS_FUNDAMENTAL ? PHASE.fund_idle : 3'h0;

   // flags are set by events and cleared by writing one; set wins
   always_comb begin
      flag_set = '0;
      flag_set[B_TOTAL_IDLE] = |(PHASE.total_idle & ~prev_total_idle);
      flag_set[B_FUND_IDLE] = |(fund_idle_in & ~prev_fund_idle);
      flag_set[B_APP_IDLE] = |(PHASE.app_idle & ~prev_app_idle);
      flag_set[B_XTO_LO +: 6] = EVENTS.crossing_timeout;
      flag_set[B_XSEEN_LO +: 6] = EVENTS.crossing_seen;
      flag_set[B_RST_DONE] = EVENTS.power_return_done;
      flag_set[B_DIP] = EVENTS.dip;
      flag_set[B_CURR_HIGH] = EVENTS.curr_high;
      flag_set[B_VOLT_HIGH] = EVENTS.high_volt;
      flag_set[B_ORDER] = EVENTS.order_fault;
      flag_set[B_NEUTRAL] = EVENTS.neutral_disagree;
      flag_set[B_CPEAK] = EVENTS.curr_peak_done;
      flag_set[B_VPEAK] = EVENTS.volt_peak_done;
      flag_clr = wr_flags ? REG_WDATA : 32'h0000_0000;
      next_flags = ((event_flags_second & ~flag_clr) | flag_set) & ENABLE_WMASK;
      next_enable = wr_enable ? (REG_WDATA & ENABLE_WMASK) : event_enable_second;
      // bit 15 stored but kept out of the gate; reset-finished pulls the line regardless
      next_irq_n = !((|(next_flags & next_enable & ENABLE_GATE)) || next_flags[B_RST_DONE]);
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         event_enable_second <= ENABLE_RESET;
      end else begin
         event_enable_second <= next_enable;
      end
   end

   // reset-finished comes up set out of any hardware reset
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         event_flags_second <= FLAGS_RESET;
      end else begin
         event_flags_second <= next_flags;
      end
   end

   // line held high during reset, falls on the first edge after release
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         SECOND_INTERRUPT_LINE_N <= 1'b1;
      end else begin
         SECOND_INTERRUPT_LINE_N <= next_irq_n;
      end
   end

   // phase source fields follow their flag: captured with it, cleared with it
   localparam int SRC_GROUPS = 3;
   localparam int SRC_LO [SRC_GROUPS] = '{PS_CURR_LO, PS_VOLT_LO, PS_DIP_LO};
   localparam int SRC_FLAG [SRC_GROUPS] = '{B_CURR_HIGH, B_VOLT_HIGH, B_DIP};
   logic [2:0] src_in [SRC_GROUPS];
   logic src_ev [SRC_GROUPS];
   assign src_in[0] = PHASE.curr_high_src;
   assign src_in[1] = PHASE.volt_high_src;
   assign src_in[2] = PHASE.dip_src;
   assign src_ev[0] = EVENTS.curr_high;
   assign src_ev[1] = EVENTS.high_volt;
   assign src_ev[2] = EVENTS.dip;

   generate
      for (genvar g = 0; g < SRC_GROUPS; g++) begin : g_src
         always_ff @(posedge CLK_SYS or negedge ARST_N) begin
            if (!ARST_N) begin
               phase_event_source[SRC_LO[g] +: 3] <= 3'h0;
            end else begin
               phase_event_source[SRC_LO[g] +: 3] <=
                  (phase_event_source[SRC_LO[g] +: 3] & ~{3{flag_clr[SRC_FLAG[g]]}})
                  | (src_in[g] & {3{src_ev[g]}});
            end
         end
      end
   endgenerate
   assign phase_event_source[2:0] = 3'h0;
   assign phase_event_source[8:6] = 3'h0;
   assign phase_event_source[15] = 1'b0;

   // no-load levels registered in the same edge as their flag
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         prev_total_idle <= 3'h0;
         prev_fund_idle <= 3'h0;
         prev_app_idle <= 3'h0;
      end else begin
         prev_total_idle <= PHASE.total_idle;
         prev_fund_idle <= fund_idle_in;
         prev_app_idle <= PHASE.app_idle;
      end
   end
   assign phase_no_load_state[NL_TOTAL_LO +: 3] = prev_total_idle;
   assign phase_no_load_state[NL_FUND_LO +: 3] = prev_fund_idle;
   assign phase_no_load_state[NL_APP_LO +: 3] = prev_app_idle;
   assign phase_no_load_state[15:9] = 7'h00;

   // only the phase-pick part of the mode register lives here; upper bits read zero
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         computation_mode <= CM_PICK_RESET;
      end else if (wr_mode) begin
         computation_mode <= REG_WDATA[CM_PICK_W-1:0];
      end
   end
   assign PULSE_ONE_PHASE_PICK = computation_mode[CM_ONE_LO +: 3];
   assign PULSE_TWO_PHASE_PICK = computation_mode[CM_TWO_LO +: 3];
   assign PULSE_THREE_PHASE_PICK = computation_mode[CM_THREE_LO +: 3];

   // read data one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         REG_RDATA <= 32'h0000_0000;
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= REG_RD;
         if (REG_RD) begin
            unique case (REG_ADDR)
               MEMPS_ADDR_ENABLE: REG_RDATA <= event_enable_second;
               MEMPS_ADDR_FLAGS: REG_RDATA <= event_flags_second | FLAGS_RSV_ONE;
               MEMPS_ADDR_PHASE_SRC: REG_RDATA <= {16'h0000, phase_event_source};
               MEMPS_ADDR_NO_LOAD: REG_RDATA <= {16'h0000, phase_no_load_state};
               MEMPS_ADDR_COMP_MODE: REG_RDATA <= {23'h00_0000, computation_mode};
               default: REG_RDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);

   sequence s_enable_write;
      wr_enable;
   endsequence
   sequence s_enable_read;
      REG_RD && (REG_ADDR == MEMPS_ADDR_ENABLE);
   endsequence
   sequence s_total_enter;
      |(PHASE.total_idle & ~prev_total_idle);
   endsequence
   sequence s_fund_enter;
      |(fund_idle_in & ~prev_fund_idle);
   endsequence
   sequence s_app_enter;
      |(PHASE.app_idle & ~prev_app_idle);
   endsequence

   line_follows_pair_a: assert property (
      (|(event_flags_second & event_enable_second & ENABLE_GATE)) |-> !SECOND_INTERRUPT_LINE_N)
      else $error("interrupt line high with an enabled flag set");

   line_released_a: assert property (
      ((event_flags_second & event_enable_second & ENABLE_GATE) == 32'h0000_0000
       && !event_flags_second[B_RST_DONE]) |-> SECOND_INTERRUPT_LINE_N)
      else $error("interrupt line low with no enabled flag");

   power_return_line_a: assert property (
      EVENTS.power_return_done |=> event_flags_second[B_RST_DONE] && !SECOND_INTERRUPT_LINE_N)
      else $error("reset-finished did not pull the line low");

   dip_source_capture_a: assert property (
      EVENTS.dip && PHASE.dip_src[0] |=> phase_event_source[PS_DIP_LO] && event_flags_second[B_DIP])
      else $error("dip phase a not recorded");

   curr_source_clear_a: assert property (
      wr_flags && REG_WDATA[B_CURR_HIGH] && !EVENTS.curr_high
      |=> !event_flags_second[B_CURR_HIGH] && phase_event_source[PS_CURR_LO +: 3] == 3'h0)
      else $error("overcurrent flag or source not cleared");

   volt_set_wins_a: assert property (
      wr_flags && REG_WDATA[B_VOLT_HIGH] && EVENTS.high_volt && PHASE.volt_high_src[2]
      |=> event_flags_second[B_VOLT_HIGH] && phase_event_source[PS_VOLT_LO + 2])
      else $error("overvoltage event lost against clear");

   no_load_together_a: assert property (
      s_total_enter |=> event_flags_second[B_TOTAL_IDLE]
      && phase_no_load_state[NL_TOTAL_LO +: 3] == $past(PHASE.total_idle))
      else $error("no-load flag and phase bits not set together");

   reserved_enable_a: assert property (
      s_enable_write ##[1:4] s_enable_read
      |=> REG_RDATA[22:21] == 2'h0 && REG_RDATA[31:25] == 7'h00)
      else $error("reserved enable bits read non-zero");

   crossing_gate_a: assert property (
      EVENTS.crossing_seen[0] && event_enable_second[B_XSEEN_LO] && !wr_enable
      |=> !SECOND_INTERRUPT_LINE_N [*2])
      else $error("crossing event did not hold the line low");

   pick_write_a: assert property (
      wr_mode |=> PULSE_THREE_PHASE_PICK == $past(REG_WDATA[CM_THREE_LO +: 3]))
      else $error("third pulse phase pick not written");

   // a write to the enable register in the same cycle may legally drop the gate
   total_idle_gate_a: assert property (
      s_total_enter ##0 (event_enable_second[B_TOTAL_IDLE] && !wr_enable)
      |=> !SECOND_INTERRUPT_LINE_N)
      else $error("total-power no-load entry did not pull the line low");

   fund_idle_gate_a: assert property (
      s_fund_enter ##0 (event_enable_second[B_FUND_IDLE] && !wr_enable)
      |=> !SECOND_INTERRUPT_LINE_N)
      else $error("fundamental no-load entry did not pull the line low");

   fund_absent_a: assert property (
      !HAS_FUNDAMENTAL |-> !event_flags_second[B_FUND_IDLE]
      && phase_no_load_state[NL_FUND_LO +: 3] == 3'h0)
      else $error("fundamental no-load reported on a variant without it");

   app_idle_gate_a: assert property (
      s_app_enter ##0 (event_enable_second[B_APP_IDLE] && !wr_enable)
      |=> !SECOND_INTERRUPT_LINE_N)
      else $error("apparent no-load entry did not pull the line low");

   missing_crossing_gate_a: assert property (
      (|(EVENTS.crossing_timeout & event_enable_second[B_XTO_LO +: 6])) && !wr_enable
      |=> !SECOND_INTERRUPT_LINE_N)
      else $error("missing crossing did not pull the line low");

   rst_mask_store_a: assert property (
      wr_enable |=> event_enable_second[B_RST_DONE] == $past(REG_WDATA[B_RST_DONE]))
      else $error("reset-finished enable bit not stored");

   dip_gate_a: assert property (
      EVENTS.dip && event_enable_second[B_DIP] && !wr_enable
      |=> !SECOND_INTERRUPT_LINE_N)
      else $error("voltage dip did not pull the line low");

   curr_high_gate_a: assert property (
      EVENTS.curr_high && event_enable_second[B_CURR_HIGH] && !wr_enable
      |=> !SECOND_INTERRUPT_LINE_N)
      else $error("overcurrent did not pull the line low");

   volt_high_gate_a: assert property (
      EVENTS.high_volt && event_enable_second[B_VOLT_HIGH] && !wr_enable
      |=> !SECOND_INTERRUPT_LINE_N)
      else $error("overvoltage did not pull the line low");

   order_gate_a: assert property (
      EVENTS.order_fault && event_enable_second[B_ORDER] && !wr_enable
      |=> !SECOND_INTERRUPT_LINE_N)
      else $error("phase order fault did not pull the line low");

   neutral_gate_a: assert property (
      EVENTS.neutral_disagree && event_enable_second[B_NEUTRAL] && !wr_enable
      |=> !SECOND_INTERRUPT_LINE_N)
      else $error("neutral disagreement did not pull the line low");

   peak_gate_a: assert property (
      ((EVENTS.curr_peak_done && event_enable_second[B_CPEAK])
       || (EVENTS.volt_peak_done && event_enable_second[B_VPEAK])) && !wr_enable
      |=> !SECOND_INTERRUPT_LINE_N)
      else $error("peak period end did not pull the line low");

   curr_source_capture_a: assert property (
      EVENTS.curr_high |=> event_flags_second[B_CURR_HIGH]
      && (phase_event_source[PS_CURR_LO +: 3] & $past(PHASE.curr_high_src))
         == $past(PHASE.curr_high_src))
      else $error("overcurrent phase not recorded");

   fund_no_load_together_a: assert property (
      s_fund_enter |=> event_flags_second[B_FUND_IDLE]
      && phase_no_load_state[NL_FUND_LO +: 3] == $past(fund_idle_in))
      else $error("fundamental no-load flag and phase bits not set together");

   app_no_load_together_a: assert property (
      s_app_enter |=> event_flags_second[B_APP_IDLE]
      && phase_no_load_state[NL_APP_LO +: 3] == $past(PHASE.app_idle)
      && phase_no_load_state[15:9] == 7'h00)
      else $error("apparent no-load flag and phase bits not set together");

   pick_one_two_write_a: assert property (
      wr_mode |=> PULSE_ONE_PHASE_PICK == $past(REG_WDATA[CM_ONE_LO +: 3])
      && PULSE_TWO_PHASE_PICK == $past(REG_WDATA[CM_TWO_LO +: 3]))
      else $error("first or second pulse phase pick not written");

endmodule

// file: verilog/memps_pkg.sv
// package: register map, bit positions and carriers for the event mask block
package memps_pkg;
   // register addresses on the serial register port
   localparam logic [15:0] MEMPS_ADDR_FLAGS = 16'hE503;
   localparam logic [15:0] MEMPS_ADDR_ENABLE = 16'hE50B;
   localparam logic [15:0] MEMPS_ADDR_PHASE_SRC = 16'hE600;
   localparam logic [15:0] MEMPS_ADDR_NO_LOAD = 16'hE608;
   localparam logic [15:0] MEMPS_ADDR_COMP_MODE = 16'hE60E;

   // event flag / enable bit positions
   localparam int B_TOTAL_IDLE = 0;
   localparam int B_FUND_IDLE = 1;
   localparam int B_APP_IDLE = 2;
   localparam int B_XTO_LO = 3;
   localparam int B_XSEEN_LO = 9;
   localparam int B_RST_DONE = 15;
   localparam int B_DIP = 16;
   localparam int B_CURR_HIGH = 17;
   localparam int B_VOLT_HIGH = 18;
   localparam int B_ORDER = 19;
   localparam int B_NEUTRAL = 20;
   localparam int B_CPEAK = 23;
   localparam int B_VPEAK = 24;

   // storable enable bits, enable bits that gate the line, reserved flag bit read as one
   localparam logic [31:0] ENABLE_WMASK = 32'h019F_FFFF;
   localparam logic [31:0] ENABLE_GATE = 32'h019F_7FFF;
   localparam logic [31:0] FLAGS_RSV_ONE = 32'h0020_0000;
   localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
   localparam logic [31:0] FLAGS_RESET = 32'h0000_8000;

   // phase register field positions
   localparam int PS_CURR_LO = 3;
   localparam int PS_VOLT_LO = 9;
   localparam int PS_DIP_LO = 12;
   localparam int NL_TOTAL_LO = 0;
   localparam int NL_FUND_LO = 3;
   localparam int NL_APP_LO = 6;

   // computation mode phase picks
   localparam int CM_PICK_W = 9;
   localparam logic [8:0] CM_PICK_RESET = 9'h1FF;
   localparam int CM_ONE_LO = 0;
   localparam int CM_TWO_LO = 3;
   localparam int CM_THREE_LO = 6;

   // one-cycle event pulses from the detection engines
   typedef struct packed {
      logic power_return_done;
      logic volt_peak_done;
      logic curr_peak_done;
      logic neutral_disagree;
      logic order_fault;
      logic high_volt;
      logic curr_high;
      logic dip;
      logic [5:0] crossing_seen;
      logic [5:0] crossing_timeout;
   } memps_events_t;

   // per-phase levels, bit 0 phase a .. bit 2 phase c
   typedef struct packed {
      logic [2:0] dip_src;
      logic [2:0] volt_high_src;
      logic [2:0] curr_high_src;
      logic [2:0] total_idle;
      logic [2:0] fund_idle;
      logic [2:0] app_idle;
   } memps_phase_t;
endpackage

// file: bench/memps_host_model.sv
// host side model driving register reads and writes
`timescale 1ns/1ps
module memps_host_model (
   input wire logic clk,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   output logic [15:0] addr,
   output logic [31:0] wdata,
   output logic wr,
   output logic rd
);
   initial begin
      addr = 16'h0000;
      wdata = 32'h0000_0000;
      wr = 1'b0;
      rd = 1'b0;
   end
   task automatic write(input logic [15:0] a, input logic [31:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   // answer comes one cycle late; a few cycles of waiting bounds a hang
   task automatic read(input logic [15:0] a, output logic [31:0] d, output bit ok);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      ok = 1'b0;
      d = 32'h0000_0000;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (rvalid === 1'b1) begin
            d = rdata;
            ok = 1'b1;
         end else begin
            @(negedge clk);
         end
      end
   endtask
endmodule

// file: bench/meter_event_mask_phase_status_tb.sv
// self-checking bench for the event enable and phase source registers
`timescale 1ns/1ps
module meter_event_mask_phase_status_tb;
   import memps_pkg::*;
   logic clk_sys;
   logic arst_n;
   logic [15:0] reg_addr;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic reg_wr;
   logic reg_rd;
   logic reg_rvalid;
   logic line_n;
   logic line_nf;
   logic [2:0] pick1;
   logic [2:0] pick2;
   logic [2:0] pick3;
   memps_events_t events;
   memps_phase_t phase;
   int bad_count;
   int cmp_count;

   memps_top u_dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .EVENTS(events),
      .PHASE(phase), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
      .SECOND_INTERRUPT_LINE_N(line_n), .PULSE_ONE_PHASE_PICK(pick1),
      .PULSE_TWO_PHASE_PICK(pick2), .PULSE_THREE_PHASE_PICK(pick3));
   memps_host_model u_host (.clk(clk_sys), .rdata(reg_rdata), .rvalid(reg_rvalid),
      .addr(reg_addr), .wdata(reg_wdata), .wr(reg_wr), .rd(reg_rd));
   // variant without fundamental metering shares the bus; only its line is watched
   memps_top #(.HAS_FUNDAMENTAL(1'b0)) u_dut_nofund (.CLK_SYS(clk_sys), .ARST_N(arst_n),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .EVENTS(events), .PHASE(phase), .REG_RDATA(), .REG_RVALID(),
      .SECOND_INTERRUPT_LINE_N(line_nf), .PULSE_ONE_PHASE_PICK(), .PULSE_TWO_PHASE_PICK(),
      .PULSE_THREE_PHASE_PICK());

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic finish_test();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic lchk(input logic e);
      chk("irq_line", {31'b0, e}, {31'b0, line_n});
   endtask
   task automatic rchk(input string n, input logic [15:0] a, input logic [31:0] e);
      logic [31:0] d;
      bit ok;
      u_host.read(a, d, ok);
      if (!ok) begin
         bad_count++;
         finish_test();
      end else begin
         chk(n, e, d);
      end
   endtask
   // one event for flag position f; idle flags come from a rising phase level
   task automatic fire(input int f);
      logic [$bits(memps_events_t)-1:0] v;
      v = '0;
      @(negedge clk_sys);
      case (f)
         0: phase.total_idle = 3'b001;
         1: phase.fund_idle = 3'b001;
         2: phase.app_idle = 3'b001;
         15: v[$bits(memps_events_t)-1] = 1'b1;
         16, 17, 18, 19, 20: v[f - 4] = 1'b1;
         23, 24: v[f - 6] = 1'b1;
         default: v[f - 3] = 1'b1;
      endcase
      events = memps_events_t'(v);
      @(negedge clk_sys);
      events = '0;
      phase = '0;
   endtask

   task automatic t_reset();
      @(negedge clk_sys);
      arst_n = 1'b0;
      repeat (10) @(negedge clk_sys);
      lchk(1'b1);
      arst_n = 1'b1;
      @(negedge clk_sys);
      lchk(1'b0);
      rchk("enable", MEMPS_ADDR_ENABLE, 32'h0000_0000);
      rchk("comp_mode", MEMPS_ADDR_COMP_MODE, 32'h0000_01FF);
      rchk("flags", MEMPS_ADDR_FLAGS, 32'h0020_8000);
      chk("picks", 32'h0000_01FF, {23'b0, pick3, pick2, pick1});
      u_host.write(MEMPS_ADDR_FLAGS, 32'h0000_8000);
      lchk(1'b1);
   endtask

   // each enable is tried with all others set first, so a swapped bit shows up
   task automatic t_gates();
      for (int f = 0; f < 25; f++) begin
         if (f != 15 && f != 21 && f != 22) begin
            u_host.write(MEMPS_ADDR_ENABLE, ENABLE_GATE & ~(32'h1 << f));
            fire(f);
            lchk(1'b1);
            rchk("flags", MEMPS_ADDR_FLAGS, (32'h1 << f) | 32'h0020_0000);
            u_host.write(MEMPS_ADDR_ENABLE, 32'h1 << f);
            lchk(1'b0);
            if (f == 1) begin
               chk("nofund_line", 32'h0000_0001, {31'b0, line_nf});
            end
            fire(f);
            lchk(1'b0);
            u_host.write(MEMPS_ADDR_FLAGS, 32'h1 << f);
            lchk(1'b1);
         end
      end
   endtask

   task automatic t_reserved();
      u_host.write(MEMPS_ADDR_ENABLE, 32'hFFFF_FFFF);
      rchk("enable", MEMPS_ADDR_ENABLE, 32'h019F_FFFF);
      lchk(1'b1);
      u_host.write(MEMPS_ADDR_ENABLE, 32'h0000_0000);
      fire(15);
      lchk(1'b0);
      u_host.write(MEMPS_ADDR_FLAGS, 32'h0000_8000);
      lchk(1'b1);
   endtask

   task automatic t_phase();
      @(negedge clk_sys);
      phase.curr_high_src = 3'b010;
      phase.volt_high_src = 3'b100;
      phase.dip_src = 3'b001;
      events.dip = 1'b1;
      events.curr_high = 1'b1;
      events.high_volt = 1'b1;
      @(negedge clk_sys);
      events = '0;
      phase = '0;
      rchk("phase_src", MEMPS_ADDR_PHASE_SRC, 32'h0000_1810);
      u_host.write(MEMPS_ADDR_FLAGS, 32'h0007_0000);
      rchk("phase_src", MEMPS_ADDR_PHASE_SRC, 32'h0000_0000);
      @(negedge clk_sys);
      phase.total_idle = 3'b101;
      phase.fund_idle = 3'b010;
      phase.app_idle = 3'b110;
      rchk("no_load", MEMPS_ADDR_NO_LOAD, 32'h0000_0195);
      rchk("flags", MEMPS_ADDR_FLAGS, 32'h0020_0007);
      phase = '0;
      rchk("no_load", MEMPS_ADDR_NO_LOAD, 32'h0000_0000);
      u_host.write(MEMPS_ADDR_FLAGS, 32'h0000_0007);
   endtask

   task automatic t_mode();
      u_host.write(MEMPS_ADDR_COMP_MODE, 32'hFFFF_FF53);
      rchk("comp_mode", MEMPS_ADDR_COMP_MODE, 32'h0000_0153);
      chk("picks", 32'h0000_0153, {23'b0, pick3, pick2, pick1});
      rchk("unmapped", 16'h1234, 32'h0000_0000);
      u_host.write(MEMPS_ADDR_PHASE_SRC, 32'h0000_FFFF);
      rchk("phase_src", MEMPS_ADDR_PHASE_SRC, 32'h0000_0000);
      u_host.write(MEMPS_ADDR_ENABLE, 32'h0000_0001);
   endtask

   initial begin
      arst_n = 1'b0;
      events = '0;
      phase = '0;
      bad_count = 0;
      cmp_count = 0;
      t_reset();
      t_reserved();
      t_gates();
      t_phase();
      t_mode();
      t_reset();
      finish_test();
   end
endmodule
